/* fcsu_cfg.svh */
`ifndef FCSU_CFG_SVH
`define FCSU_CFG_SVH
// register byte addresses
`define FCSU_OFS_STATUS   12'h000
`define FCSU_OFS_COMMAND  12'h004
`define FCSU_OFS_DIVIDER  12'h008
`define FCSU_OFS_PROTECT  12'h00C
`define FCSU_OFS_ADDR     12'h010
`define FCSU_OFS_DATA     12'h014
`define FCSU_OFS_SECURITY 12'h018
// status bit positions
`define FCSU_BIT_CBEF     7
`define FCSU_BIT_CCF      6
`define FCSU_BIT_PVIOL    5
`define FCSU_BIT_ACCERR   4
`define FCSU_BIT_BLANK    2
// command codes
`define FCSU_CMD_BLANK    8'h05
`define FCSU_CMD_BYTE     8'h20
`define FCSU_CMD_BURST    8'h25
`define FCSU_CMD_PAGE     8'h40
`define FCSU_CMD_MASS     8'h41
// erased byte value
`define FCSU_ERASED       8'hFF
// unsecured security code
`define FCSU_SEC_OPEN     2'h2
// reset values
`define FCSU_RST_SEC      2'h3
`define FCSU_RST_PROT     8'hFF
// page size in bytes
`define FCSU_PAGE_BYTES   512
`endif

/* fcsu_pkg.sv */
package fcsu_pkg;
  typedef enum logic [2:0] {
    FCSU_OP_BLANK,
    FCSU_OP_BYTE,
    FCSU_OP_BURST,
    FCSU_OP_PAGE,
    FCSU_OP_MASS,
    FCSU_OP_BAD
  } fcsu_op_e;

  typedef struct packed {
    fcsu_op_e    op;
    logic [15:0] addr;
    logic [7:0]  data;
  } fcsu_req_s;

  typedef enum logic [1:0] {
    FCSU_SEQ_IDLE,
    FCSU_SEQ_DATA,
    FCSU_SEQ_CMD
  } fcsu_seq_e;
endpackage : fcsu_pkg

/* fcsu_top.sv */
`timescale 1ns/1ns
`include "fcsu_cfg.svh"

module fcsu_top
  import fcsu_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              stop_mode,
  output fcsu_req_s              arr_req,
  output logic                   arr_start,
  input  wire logic              arr_busy,
  input  wire logic              arr_erased,
  output logic      [1:0]        security_state_field
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_stat = paddr == `FCSU_OFS_STATUS;
  wire hit_cmd  = paddr == `FCSU_OFS_COMMAND;
  wire hit_div  = paddr == `FCSU_OFS_DIVIDER;
  wire hit_prot = paddr == `FCSU_OFS_PROTECT;
  wire hit_addr = paddr == `FCSU_OFS_ADDR;
  wire hit_data = paddr == `FCSU_OFS_DATA;
  wire hit_sec  = paddr == `FCSU_OFS_SECURITY;
  wire mapped   = hit_stat | hit_cmd | hit_div | hit_prot | hit_addr | hit_data | hit_sec;

  logic [7:0]        cmd_q;
  logic [7:0]        div_q;
  logic              div_set_q;
  logic [7:0]        prot_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        data_q;
  fcsu_seq_e         seq_q;
  logic              cbef_q, ccf_q, pviol_q, accerr_q, blank_q;
  logic              pend_q;
  fcsu_req_s         pend_d;
  logic              run_q;
  fcsu_op_e          run_op_q;
  logic [1:0]        sec_q;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // code decode
  fcsu_op_e dec_op;
  assign dec_op = (cmd_q == `FCSU_CMD_BLANK) ? FCSU_OP_BLANK :
                  (cmd_q == `FCSU_CMD_BYTE)  ? FCSU_OP_BYTE  :
                  (cmd_q == `FCSU_CMD_BURST) ? FCSU_OP_BURST :
                  (cmd_q == `FCSU_CMD_PAGE)  ? FCSU_OP_PAGE  :
                  (cmd_q == `FCSU_CMD_MASS)  ? FCSU_OP_MASS  : FCSU_OP_BAD;

  wire launch   = wr & hit_stat & pwdata[`FCSU_BIT_CBEF] & cbef_q;
  wire is_write = dec_op inside {FCSU_OP_BYTE, FCSU_OP_BURST, FCSU_OP_PAGE, FCSU_OP_MASS};
  // protected region is addresses at or above prot_q << 8; 0xFF disables.
  // protected region
  wire prot_on  = prot_q != `FCSU_RST_PROT;
  wire in_prot  = prot_on & (addr_q[ADDR_W-1 -: 8] >= prot_q);
  wire mass_hit = prot_on & (dec_op == FCSU_OP_MASS);
  wire viol     = launch & is_write & (in_prot | mass_hit);
  wire seq_bad  = seq_q != FCSU_SEQ_CMD;
  wire no_div   = is_write & ~div_set_q;
  wire bad      = launch & (seq_bad | no_div | dec_op == FCSU_OP_BAD);
  wire good     = launch & ~bad & ~viol;
  wire queue_ok = ~run_q | (dec_op == FCSU_OP_BURST & run_op_q == FCSU_OP_BURST);
  wire accept   = good & queue_ok;
  wire stop_err = stop_mode & (run_q | pend_q);
  wire handoff  = pend_q & ~arr_busy & ~arr_start;
  wire run_end  = run_q & ~arr_busy & ~arr_start;

  assign pend_d = '{op: dec_op, addr: 16'(addr_q), data: data_q};

  // ----------------------------------------
  // sequence tracking
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      seq_q <= FCSU_SEQ_IDLE;
    else if (launch)
      seq_q <= FCSU_SEQ_IDLE;
    else if (wr & hit_data)
      seq_q <= FCSU_SEQ_DATA;
    else if (wr & hit_cmd)
      seq_q <= (seq_q == FCSU_SEQ_DATA) ? FCSU_SEQ_CMD : FCSU_SEQ_IDLE;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cmd_q     <= 8'h00;
      div_q     <= 8'h00;
      div_set_q <= 1'b0;
      prot_q    <= `FCSU_RST_PROT;
      addr_q    <= '0;
      data_q    <= 8'h00;
    end
    else
    begin
      if (wr & hit_cmd)  cmd_q  <= pwdata[7:0];
      if (wr & hit_div)  div_q  <= pwdata[7:0];
      if (wr & hit_div)  div_set_q <= 1'b1;
      // protection may only grow (lower boundary)
      if (wr & hit_prot & pwdata[7:0] < prot_q) prot_q <= pwdata[7:0];
      if (wr & hit_addr) addr_q <= pwdata[ADDR_W-1:0];
      if (wr & hit_data) data_q <= pwdata[7:0];
    end

  // ----------------------------------------
  // execution
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pend_q    <= 1'b0;
      run_q     <= 1'b0;
      run_op_q  <= FCSU_OP_BLANK;
      arr_start <= 1'b0;
      arr_req   <= '0;
    end
    else
    begin
      arr_start <= 1'b0;
      if (stop_err)
      begin
        pend_q <= 1'b0;
        run_q  <= 1'b0;
      end
      else if (accept & ~run_q)
      begin
        run_q     <= 1'b1;
        run_op_q  <= dec_op;
        arr_req   <= pend_d;
        arr_start <= 1'b1;
      end
      else if (accept)
      begin
        pend_q  <= 1'b1;
        arr_req <= pend_d;
      end
      else if (handoff)
      begin
        pend_q    <= 1'b0;
        arr_start <= 1'b1;
      end
      else if (run_end)
        run_q <= 1'b0;
    end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // buffer refills when no burst is waiting and no non-burst command is running
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cbef_q <= 1'b1;
    else if (launch | handoff)
      cbef_q <= 1'b0;
    else if (~pend_q & ~(run_q & run_op_q != FCSU_OP_BURST))
      cbef_q <= 1'b1;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ccf_q <= 1'b1;
    else if (accept)
      ccf_q <= 1'b0;
    else
      ccf_q <= cbef_q & ~run_q & ~pend_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pviol_q <= 1'b0;
    else if (viol)
      pviol_q <= 1'b1;
    else if (wr & hit_stat & pwdata[`FCSU_BIT_PVIOL])
      pviol_q <= 1'b0;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      accerr_q <= 1'b0;
    else if (bad | stop_err)
      accerr_q <= 1'b1;
    else if (wr & hit_stat & pwdata[`FCSU_BIT_ACCERR])
      accerr_q <= 1'b0;

  wire blank_done = run_end & run_op_q == FCSU_OP_BLANK;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      blank_q <= 1'b0;
    else if (blank_done)
      blank_q <= arr_erased;
    else if (good)
      blank_q <= 1'b0;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sec_q <= `FCSU_RST_SEC;
    else if (blank_done & arr_erased)
      sec_q <= `FCSU_SEC_OPEN;

  assign security_state_field = sec_q;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // reserved zero
  wire [7:0] stat_rd = {cbef_q, ccf_q, pviol_q, accerr_q, 1'b0, blank_q, 2'b00};
  wire [31:0] rd_mux = hit_stat ? {24'h000000, stat_rd} :
                       hit_cmd  ? {24'h000000, cmd_q} :
                       hit_div  ? {24'h000000, div_q} :
                       hit_prot ? {24'h000000, prot_q} :
                       hit_addr ? {{(32-ADDR_W){1'b0}}, addr_q} :
                       hit_data ? {24'h000000, data_q} :
                       hit_sec  ? {30'h00000000, sec_q} : 32'h00000000;
  assign prdata = (acc & ~pwrite) ? rd_mux : 32'h00000000;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_launch_bad; launch & (dec_op == FCSU_OP_BAD); endsequence

  a_illegal_code_err: assert property (s_launch_bad |=> accerr_q)
    else $error("illegal code did not set access error");
  a_illegal_no_start: assert property (s_launch_bad |=> !arr_start)
    else $error("illegal code started array");
  a_viol_flag: assert property (viol |=> pviol_q && !arr_start)
    else $error("protection violation not flagged");
  a_viol_hold: assert property (pviol_q && !(wr && hit_stat) |=> pviol_q)
    else $error("violation flag cleared without write");
  a_seq_err: assert property (launch && seq_bad |=> accerr_q)
    else $error("sequence error not flagged");
  a_div_err: assert property (launch && no_div |=> accerr_q)
    else $error("missing divider not flagged");
  a_stop_err: assert property (stop_err |=> accerr_q && !run_q)
    else $error("stop in command not flagged");
  a_launch_clear: assert property (launch |=> !cbef_q)
    else $error("buffer empty not cleared on launch");
  a_ccf_clear: assert property (accept |=> !ccf_q)
    else $error("complete flag not cleared on launch");
  a_rsvd_zero: assert property (acc && !pwrite && hit_stat |->
    prdata[3] == 1'b0 && prdata[1:0] == 2'b00)
    else $error("reserved status bits not zero");
  a_blank_sec: assert property (blank_done && arr_erased |=>
    blank_q && sec_q == `FCSU_SEC_OPEN)
    else $error("blank pass did not unsecure");

  // ----------------------------------------
  // buffer and flag checks
  // ----------------------------------------
  // queued burst reaches the array only at handoff
  sequence s_handoff; handoff && !stop_err; endsequence

  a_handoff_start: assert property (s_handoff |=> arr_start && !pend_q)
    else $error("buffered burst not handed off");
  a_handoff_cbef: assert property (s_handoff |=> !cbef_q)
    else $error("buffer empty not cleared on handoff");
  a_idle_no_start: assert property (!(accept && !run_q) && !handoff |=> !arr_start)
    else $error("array started without a command");

  // full buffer must block further launches
  a_full_buffer: assert property (pend_q |-> !cbef_q)
    else $error("buffer shown empty while full");

  a_ccf_busy: assert property (run_q |-> !ccf_q)
    else $error("complete flag set while running");
  a_ccf_set: assert property (cbef_q && !run_q && !pend_q && !accept |=> ccf_q)
    else $error("complete flag not set when idle");

  a_stop_clear: assert property (stop_err |=> !pend_q)
    else $error("buffered command kept after stop");
  a_accerr_hold: assert property (accerr_q && !(wr && hit_stat) |=> accerr_q)
    else $error("access error cleared without write");

  a_blank_fail: assert property (blank_done && !arr_erased |=> !blank_q)
    else $error("blank flag set on failed check");
  a_blank_clear: assert property (good && !blank_done |=> !blank_q)
    else $error("blank flag not cleared on launch");

  a_start_code: assert property (accept && !run_q && !stop_err |=>
    arr_start && arr_req.op == $past(dec_op))
    else $error("array started with wrong operation");
  a_bad_no_op: assert property (arr_start |-> arr_req.op != FCSU_OP_BAD)
    else $error("illegal operation sent to array");
  a_prot_block: assert property (launch && is_write && in_prot |=> pviol_q && !arr_start)
    else $error("protected location not blocked");

endmodule : fcsu_top

/* fcsu_top_test.sv */
`timescale 1ns/1ns
`include "fcsu_cfg.svh"
module fcsu_top_test
  import fcsu_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] st;
    fcsu_op_e   op;
    logic       inc;
    logic       erased;
    logic [1:0] sec;
  } fcsu_row_s;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stop_mode;
  fcsu_req_s   arr_req;
  logic        arr_start;
  logic        arr_busy;
  logic        arr_erased;
  logic [1:0]  security_state_field;
  logic [31:0] rd_data;
  logic        rd_err;
  fcsu_op_e    last_op;
  fcsu_req_s   last_req;
  int          error_cnt;
  int          total_checks;
  int          start_cnt;
  int          busy_cnt;
  int          busy_len;
  int          s0;
  fcsu_row_s   rows [7] = '{
    '{8'h05, 8'hC4, FCSU_OP_BLANK, 1'b1, 1'b1, 2'h2},
    '{8'h05, 8'hC0, FCSU_OP_BLANK, 1'b1, 1'b0, 2'h2},
    '{8'h20, 8'hC0, FCSU_OP_BYTE,  1'b1, 1'b0, 2'h2},
    '{8'h25, 8'hC0, FCSU_OP_BURST, 1'b1, 1'b0, 2'h2},
    '{8'h40, 8'hC0, FCSU_OP_PAGE,  1'b1, 1'b0, 2'h2},
    '{8'h41, 8'hC0, FCSU_OP_MASS,  1'b1, 1'b0, 2'h2},
    '{8'h33, 8'hD0, FCSU_OP_BAD,   1'b0, 1'b0, 2'h2}};

  fcsu_top fcsu_top_inst (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .stop_mode            (stop_mode),
    .arr_req              (arr_req),
    .arr_start            (arr_start),
    .arr_busy             (arr_busy),
    .arr_erased           (arr_erased),
    .security_state_field (security_state_field)
  );

  always #10 pclk = ~pclk;

  // ------------------------------------------------
  // array stand-in: busy from the cycle after start
  // ------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arr_busy <= 1'b0;
      busy_cnt <= 0;
    end
    else if (arr_start === 1'b1)
    begin
      arr_busy  <= 1'b1;
      busy_cnt  <= busy_len;
      start_cnt <= start_cnt + 1;
      last_op   <= arr_req.op;
      last_req  <= arr_req;
    end
    else if (busy_cnt > 1)
      busy_cnt <= busy_cnt - 1;
    else
    begin
      arr_busy <= 1'b0;
      busy_cnt <= 0;
    end
  end

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic wrap_up;
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 50)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_cmd(input logic [15:0] a, input logic [7:0] cmd);
    apb(1'b1, `FCSU_OFS_ADDR, {16'h0, a});
    apb(1'b1, `FCSU_OFS_DATA, 32'h5A);
    apb(1'b1, `FCSU_OFS_COMMAND, {24'h0, cmd});
    apb(1'b1, `FCSU_OFS_STATUS, 32'h80);
  endtask : do_cmd

  // poll until buffer empty and complete; bounded
  task automatic wait_idle;
    int i;
    i = 0;
    do
    begin
      apb(1'b0, `FCSU_OFS_STATUS, 32'h0);
      i++;
    end
    while (rd_data[7:6] !== 2'b11 && i < 40);
    if (i >= 40)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask : wait_idle

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h0;
    pwdata = 32'h0; stop_mode = 0; arr_erased = 0; error_cnt = 0; total_checks = 0;
    busy_len = 4;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    chk(rd_data, 32'hC0);
    apb(1'b0, `FCSU_OFS_SECURITY, 32'h0);
    chk(rd_data, 32'h3);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd_err, rd_data[30:0]}, 32'h80000000);
    // no divider yet: program refused
    s0 = start_cnt;
    do_cmd(16'h1000, `FCSU_CMD_BYTE);
    wait_idle();
    chk(rd_data, 32'hD0);
    chk(32'(start_cnt - s0), 32'h0);
    // writes of zero and to fixed bits change nothing
    apb(1'b1, `FCSU_OFS_STATUS, 32'h4F);
    apb(1'b0, `FCSU_OFS_STATUS, 32'h0);
    chk(rd_data, 32'hD0);
    apb(1'b1, `FCSU_OFS_STATUS, 32'h10);
    apb(1'b0, `FCSU_OFS_STATUS, 32'h0);
    chk(rd_data, 32'hC0);
    apb(1'b1, `FCSU_OFS_DIVIDER, 32'h13);
    // command codes, one row each, two for blank check
    // blank check unlocks
    foreach (rows[k])
    begin
      arr_erased <= rows[k].erased;
      s0 = start_cnt;
      do_cmd(16'h1000, rows[k].cmd);
      wait_idle();
      chk(rd_data, {24'h0, rows[k].st});
      chk(32'(start_cnt - s0), {31'h0, rows[k].inc});
      if (rows[k].inc)
      begin
        chk(32'(last_op), 32'(rows[k].op));
        chk({8'h0, last_req.addr, last_req.data}, 32'h0010005A);
      end
      chk({30'h0, security_state_field}, {30'h0, rows[k].sec});
      apb(1'b1, `FCSU_OFS_STATUS, 32'h30);
    end
    // broken sequences: command without data, launch without command
    apb(1'b1, `FCSU_OFS_COMMAND, 32'h20);
    apb(1'b1, `FCSU_OFS_STATUS, 32'h80);
    wait_idle();
    chk(rd_data, 32'hD0);
    apb(1'b1, `FCSU_OFS_STATUS, 32'h10);
    apb(1'b1, `FCSU_OFS_DATA, 32'h11);
    apb(1'b1, `FCSU_OFS_STATUS, 32'h80);
    wait_idle();
    chk(rd_data, 32'hD0);
    apb(1'b1, `FCSU_OFS_STATUS, 32'h10);
    // long runs: stop mode mid-command, then queued burst
    busy_len = 12;
    do_cmd(16'h1000, `FCSU_CMD_PAGE);
    repeat (3) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    stop_mode <= 1'b0;
    wait_idle();
    chk(rd_data & 32'h10, 32'h10);
    apb(1'b1, `FCSU_OFS_STATUS, 32'h30);
    // long enough that the second burst is queued, not started
    busy_len = 30;
    s0 = start_cnt;
    do_cmd(16'h1000, `FCSU_CMD_BURST);
    for (int i = 0; i < 20 && rd_data[7] !== 1'b1; i++)
      apb(1'b0, `FCSU_OFS_STATUS, 32'h0);
    if (rd_data[7] !== 1'b1)
    begin
      error_cnt++;
      wrap_up();
    end
    do_cmd(16'h1001, `FCSU_CMD_BURST);
    apb(1'b0, `FCSU_OFS_STATUS, 32'h0);
    chk(rd_data, 32'h00);
    wait_idle();
    chk(rd_data, 32'hC0);
    chk(32'(start_cnt - s0), 32'h2);
    chk({8'h0, last_req.addr, last_req.data}, 32'h0010015A);
    // non-burst while running is dropped
    s0 = start_cnt;
    do_cmd(16'h1000, `FCSU_CMD_BYTE);
    do_cmd(16'h1002, `FCSU_CMD_BYTE);
    wait_idle();
    chk(32'(start_cnt - s0), 32'h1);
    // protected region: upper half
    busy_len = 4;
    apb(1'b1, `FCSU_OFS_PROTECT, 32'h80);
    s0 = start_cnt;
    for (int i = 0; i < 2; i++)
    begin
      do_cmd(i ? 16'h1000 : 16'h8000, i ? `FCSU_CMD_MASS : `FCSU_CMD_BYTE);
      wait_idle();
      chk(rd_data, 32'hE0);
      apb(1'b1, `FCSU_OFS_STATUS, 32'h00);
      apb(1'b0, `FCSU_OFS_STATUS, 32'h0);
      chk(rd_data, 32'hE0);
      apb(1'b1, `FCSU_OFS_STATUS, 32'h20);
    end
    chk(32'(start_cnt - s0), 32'h0);
    apb(1'b0, `FCSU_OFS_STATUS, 32'h0);
    chk(rd_data, 32'hC0);
    wrap_up();
  end
endmodule : fcsu_top_test
